// ### src/pci_top.sv
// Pin change interrupt: eight watched pins, edge enables, flags, interrupt.
// Assumes a core on the same clock drives the register port and sleep level.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "pci_consts.svh"

module pci_top
    import pci_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RSTN_IN,
    // Watched port pins, asynchronous
    input wire logic [`PCI_PIN_N-1:0] WATCHED_PIN_IN,
    // Register port from the core
    input wire logic [`PCI_ADDR_W-1:0] ADDR_IN,
    input wire logic [`PCI_DATA_W-1:0] WR_DATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [`PCI_DATA_W-1:0] RD_DATA_OUT,
    // Core power state and requests
    input wire logic SLEEP_IN,
    output logic IRQ_OUT,
    output logic WAKE_OUT
);

    // Register state and its next value
    pci_state_t s_q;
    pci_state_t s_d;
    // Request bundle from the port
    pci_bus_req_t req;
    // Synchronised pins
    logic [`PCI_PIN_N-1:0] pin_sync;
    // Edge pulses
    pci_edge_t edges;
    // Flags to set this cycle
    logic [`PCI_PIN_N-1:0] set_mask;
    // Summary of all pin flags
    logic change_int_summary_flag;

    // True when a strobe targets the given offset
    function automatic logic hit(input logic strobe, input logic [`PCI_ADDR_W-1:0] addr,
                                 input logic [`PCI_ADDR_W-1:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction

    assign req.addr = ADDR_IN;
    assign req.wdata = WR_DATA_IN;
    assign req.wr = WR_IN;
    assign req.rd = RD_IN;

    // Pins cross into the clock domain here
    pci_sync #(
        .WIDTH(`PCI_PIN_N)
    ) u_sync (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .async_in(WATCHED_PIN_IN),
        .sync_out(pin_sync)
    );

    // One-cycle pulses per polarity
    pci_edge #(
        .WIDTH(`PCI_PIN_N)
    ) u_edge (
        .clk_in(CLK_IN),
        .rstn_in(RSTN_IN),
        .sample_in(pin_sync),
        .rise_out(edges.rise),
        .fall_out(edges.fall)
    );

    // Enabled edges; runs whatever the master enable holds
    always_comb begin
        set_mask = (edges.rise & s_q.rise_edge_enable)
                 | (edges.fall & s_q.fall_edge_enable);
    end

    // Any flag set
    assign change_int_summary_flag = |s_q.pin_change_flags;

    // Next state of every register
    always_comb begin
        s_d = s_q;
        // Enable registers
        if (hit(req.wr, req.addr, `PCI_OFS_RISE)) begin
            s_d.rise_edge_enable = req.wdata;
        end
        if (hit(req.wr, req.addr, `PCI_OFS_FALL)) begin
            s_d.fall_edge_enable = req.wdata;
        end
        // Flags: written value, then new edges on top so they win
        if (hit(req.wr, req.addr, `PCI_OFS_FLAGS)) begin
            s_d.pin_change_flags = req.wdata | set_mask;
        end else begin
            s_d.pin_change_flags = s_q.pin_change_flags | set_mask;
        end
        // Master enable lives in the control register
        if (hit(req.wr, req.addr, `PCI_OFS_CTRL)) begin
            s_d.change_int_master_enable = req.wdata[`PCI_CTRL_MASTER_BIT];
        end
        // Sticky event bits: write one to clear, set wins
        if (hit(req.wr, req.addr, `PCI_OFS_STATUS)) begin
            s_d.evt_status = (s_q.evt_status & ~req.wdata) | set_mask;
        end else begin
            s_d.evt_status = s_q.evt_status | set_mask;
        end
        // Event mask
        if (hit(req.wr, req.addr, `PCI_OFS_MASK)) begin
            s_d.evt_mask = req.wdata;
        end
        // Read data stand for one cycle only
        s_d.rd_data = `PCI_RD_IDLE;
        if (req.rd) begin
            unique case (req.addr)
                `PCI_OFS_RISE: s_d.rd_data = s_q.rise_edge_enable;
                `PCI_OFS_FALL: s_d.rd_data = s_q.fall_edge_enable;
                `PCI_OFS_FLAGS: s_d.rd_data = s_q.pin_change_flags;
                `PCI_OFS_CTRL: begin
                    s_d.rd_data[`PCI_CTRL_MASTER_BIT] = s_q.change_int_master_enable;
                    s_d.rd_data[`PCI_CTRL_SUMMARY_BIT] = change_int_summary_flag;
                end
                `PCI_OFS_STATUS: s_d.rd_data = s_q.evt_status;
                `PCI_OFS_MASK: s_d.rd_data = s_q.evt_mask;
                // Unmapped offsets read as zero
                default: s_d.rd_data = `PCI_RD_IDLE;
            endcase
        end
    end

    // Every reset kind clears flags and enables
    always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
            s_q.rise_edge_enable <= `PCI_RST_ENABLE;
            s_q.fall_edge_enable <= `PCI_RST_ENABLE;
            s_q.pin_change_flags <= `PCI_RST_FLAGS;
            s_q.change_int_master_enable <= `PCI_RST_MASTER;
            s_q.evt_status <= `PCI_RST_STATUS;
            s_q.evt_mask <= `PCI_RST_MASK;
            s_q.rd_data <= `PCI_RD_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Request only through the master enable
    assign IRQ_OUT = s_q.change_int_master_enable
                   && |(s_q.evt_status & s_q.evt_mask);
    // Wake comes from the stored flag, so the flag is visible first
    assign WAKE_OUT = SLEEP_IN && s_q.change_int_master_enable
                    && change_int_summary_flag;
    assign RD_DATA_OUT = s_q.rd_data;

    // Enabled edge leaves its flag set next cycle
    chk_flag_on_edge: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (|set_mask) |=> ((s_q.pin_change_flags & $past(set_mask)) == $past(set_mask)))
        else $error("enabled edge did not set its flag");

    // Edge wins over a clearing write
    chk_edge_wins_clear: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_FLAGS) && (|set_mask))
        |=> (s_q.pin_change_flags == ($past(req.wdata) | $past(set_mask))))
        else $error("flag clear lost a coincident edge");

    // Quiet write of zero clears the flags
    chk_flag_clear: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_FLAGS) && (set_mask == '0))
        |=> (s_q.pin_change_flags == $past(req.wdata)))
        else $error("flag write not honoured");

    // Reset clears enables and flags
    chk_reset_clears: assert property (
        @(posedge CLK_IN)
        (!RSTN_IN) |=> (s_q.pin_change_flags == '0 && s_q.rise_edge_enable == '0
                        && s_q.fall_edge_enable == '0 && !IRQ_OUT))
        else $error("reset left state set");

    // No request while the master enable is clear
    chk_master_gate: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (!s_q.change_int_master_enable) |-> (!IRQ_OUT && !WAKE_OUT))
        else $error("request raised with master enable clear");

    // Enabled edge in sleep with the master on raises wake next cycle
    chk_wake_flag: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (SLEEP_IN && s_q.change_int_master_enable && (|set_mask)) |=> WAKE_OUT
            || !SLEEP_IN || !s_q.change_int_master_enable)
        else $error("edge in sleep did not wake the core");

    // Summary bit read back matches the flags
    chk_summary_read: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.rd, req.addr, `PCI_OFS_CTRL))
        |=> (RD_DATA_OUT[`PCI_CTRL_SUMMARY_BIT] == $past(|s_q.pin_change_flags)))
        else $error("summary flag read wrong");

    // Enable writes land
    chk_enable_write: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_RISE)) |=> (s_q.rise_edge_enable == $past(req.wdata)))
        else $error("rising enable write lost");

    chk_fall_write: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_FALL)) |=> (s_q.fall_edge_enable == $past(req.wdata)))
        else $error("falling enable write lost");

    // Both enables: either polarity sets the flag
    chk_both_polarity: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        ((edges.fall[0] || edges.rise[0]) && s_q.rise_edge_enable[0]
            && s_q.fall_edge_enable[0]) |=> s_q.pin_change_flags[0])
        else $error("dual enable missed an edge");

    // Unmasked edge with the master on raises the request next cycle
    chk_irq_raise: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (s_q.change_int_master_enable && (|(set_mask & s_q.evt_mask))
            && !hit(req.wr, req.addr, `PCI_OFS_CTRL) && !hit(req.wr, req.addr, `PCI_OFS_MASK))
        |=> IRQ_OUT)
        else $error("unmasked edge raised no request");

    // Every enabled edge also lands in the sticky event bits
    chk_status_set: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (|set_mask) |=> ((s_q.evt_status & $past(set_mask)) == $past(set_mask)))
        else $error("enabled edge did not set its event bit");

    // Flags only drop through a write to the flag register
    chk_flags_hold: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (!hit(req.wr, req.addr, `PCI_OFS_FLAGS))
        |=> ((s_q.pin_change_flags & $past(s_q.pin_change_flags)) == $past(s_q.pin_change_flags)))
        else $error("flag dropped without a write");

    // Without a write, a new flag bit needs an enabled edge behind it
    chk_no_spurious_flag: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (!hit(req.wr, req.addr, `PCI_OFS_FLAGS))
        |=> ((s_q.pin_change_flags & ~$past(s_q.pin_change_flags))
            == ($past(set_mask) & ~$past(s_q.pin_change_flags))))
        else $error("flag set with no enabled edge");

    // Raw rising pulse on an armed pin sets its flag, apart from the merge
    chk_rise_sets: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (|(edges.rise & s_q.rise_edge_enable))
        |=> ((s_q.pin_change_flags & $past(edges.rise & s_q.rise_edge_enable))
            == $past(edges.rise & s_q.rise_edge_enable)))
        else $error("armed rising edge left no flag");

    // Raw falling pulse on an armed pin sets its flag, apart from the merge
    chk_fall_sets: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (|(edges.fall & s_q.fall_edge_enable))
        |=> ((s_q.pin_change_flags & $past(edges.fall & s_q.fall_edge_enable))
            == $past(edges.fall & s_q.fall_edge_enable)))
        else $error("armed falling edge left no flag");

    // A pulse never lasts two cycles: the sample has to settle first
    chk_pulse_single: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (|(edges.rise | edges.fall))
        |=> (((edges.rise & $past(edges.rise)) | (edges.fall & $past(edges.fall))) == '0))
        else $error("edge pulse longer than one cycle");

    // One pin cannot rise and fall in the same cycle
    chk_pulse_exclusive: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        ((edges.rise & edges.fall) == '0))
        else $error("rising and falling pulse on one pin");

    // Flag read returns the register as it stood at the strobe
    chk_flags_read: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.rd, req.addr, `PCI_OFS_FLAGS))
        |=> (RD_DATA_OUT == $past(s_q.pin_change_flags)))
        else $error("flag read returned wrong value");

    // Master enable write lands in one cycle
    chk_ctrl_write: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_CTRL))
        |=> (s_q.change_int_master_enable == $past(req.wdata[`PCI_CTRL_MASTER_BIT])))
        else $error("master enable write lost");

    // Clearing the master drops both requests at once, flags or not
    chk_master_off: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_CTRL) && !req.wdata[`PCI_CTRL_MASTER_BIT])
        |=> (!IRQ_OUT && !WAKE_OUT))
        else $error("request outlived the master enable");

    // Enables hold when neither is written
    chk_enable_hold: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (!hit(req.wr, req.addr, `PCI_OFS_RISE) && !hit(req.wr, req.addr, `PCI_OFS_FALL))
        |=> ($stable(s_q.rise_edge_enable) && $stable(s_q.fall_edge_enable)))
        else $error("enable changed without a write");

    // Summary follows the flags right after a flag write
    chk_summary_live: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (hit(req.wr, req.addr, `PCI_OFS_FLAGS))
        |=> (change_int_summary_flag == (|($past(req.wdata) | $past(set_mask)))))
        else $error("summary flag out of step with the flags");

    // Master clear still lets enabled edges flag
    chk_flag_without_master: assert property (
        @(posedge CLK_IN) disable iff (!RSTN_IN)
        (!s_q.change_int_master_enable && (|set_mask)) |=> (|s_q.pin_change_flags))
        else $error("edge not flagged with master clear");

endmodule

// ### src/pci_consts.svh
// Constants of the pin change interrupt block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PCI_CONSTS_SVH
`define PCI_CONSTS_SVH

// Widths
`define PCI_PIN_N 8
`define PCI_DATA_W 8
`define PCI_ADDR_W 3

// Register offsets (word index on the plain port)
`define PCI_OFS_RISE 3'h0
`define PCI_OFS_FALL 3'h1
`define PCI_OFS_FLAGS 3'h2
`define PCI_OFS_CTRL 3'h3
`define PCI_OFS_STATUS 3'h4
`define PCI_OFS_MASK 3'h5

// Control register fields
`define PCI_CTRL_MASTER_BIT 4
`define PCI_CTRL_SUMMARY_BIT 0

// Reset values
`define PCI_RST_ENABLE 8'h00
`define PCI_RST_FLAGS 8'h00
`define PCI_RST_STATUS 8'h00
`define PCI_RST_MASK 8'hFF
`define PCI_RST_MASTER 1'h0
`define PCI_RD_IDLE 8'h00

// Edge detector warm-up: cycles after reset before samples are trusted
`define PCI_EDGE_WARM 2'h3

`endif

// ### src/pci_pkg.sv
// Types shared by the pin change interrupt modules.
// Assumes the constants header sits beside it on the include path.
`include "pci_consts.svh"

package pci_pkg;

    // One request on the plain register port
    typedef struct packed {
        logic [`PCI_ADDR_W-1:0] addr;
        logic [`PCI_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pci_bus_req_t;

    // Edge pulses, one bit per pin and polarity
    typedef struct packed {
        logic [`PCI_PIN_N-1:0] rise;
        logic [`PCI_PIN_N-1:0] fall;
    } pci_edge_t;

    // Whole register state of the top module
    typedef struct packed {
        logic [`PCI_PIN_N-1:0] rise_edge_enable;
        logic [`PCI_PIN_N-1:0] fall_edge_enable;
        logic [`PCI_PIN_N-1:0] pin_change_flags;
        logic change_int_master_enable;
        logic [`PCI_PIN_N-1:0] evt_status;
        logic [`PCI_PIN_N-1:0] evt_mask;
        logic [`PCI_DATA_W-1:0] rd_data;
    } pci_state_t;

endpackage

// ### src/pci_sync.sv
// Two-stage synchroniser for the watched pins.
// Assumes asynchronous pin levels and a synchronous active-low reset.
`timescale 1ns/10ps
`include "pci_consts.svh"

module pci_sync
    import pci_pkg::*;
#(
    parameter int WIDTH = `PCI_PIN_N
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Pins and synchronised copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // Both stages kept as one packed state
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pci_sync_state_t;

    pci_sync_state_t s_q;
    pci_sync_state_t s_d;

    // First stage feeds only the second one
    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    // Register both stages
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule

// ### src/pci_edge.sv
// Edge detector over synchronised pin samples.
// Assumes its input already passed the two-stage synchroniser.
`timescale 1ns/10ps
`include "pci_consts.svh"

module pci_edge
    import pci_pkg::*;
#(
    parameter int WIDTH = `PCI_PIN_N
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Synchronised sample and edge pulses
    input wire logic [WIDTH-1:0] sample_in,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);

    // Previous sample plus a warm-up count
    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic [1:0] warm;
    } pci_edge_state_t;

    pci_edge_state_t s_q;
    pci_edge_state_t s_d;
    // High once both compared samples come from the real pins
    logic armed;

    // Keep the last sample; count up until the synchroniser is flushed
    always_comb begin
        s_d.prev = sample_in;
        s_d.warm = (s_q.warm == `PCI_EDGE_WARM) ? `PCI_EDGE_WARM : (s_q.warm + 2'h1);
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Synchroniser leaves reset at zero, so a pin held high would look like a rise
    assign armed = (s_q.warm == `PCI_EDGE_WARM);
    assign rise_out = armed ? (sample_in & ~s_q.prev) : '0;
    assign fall_out = armed ? (~sample_in & s_q.prev) : '0;

endmodule

// ### test/pci_pin_model.sv
// Far-side model: the source that drives the eight watched pins.
// Assumes the bench changes the requested level just after a rising edge.
`timescale 1ns/10ps

module pci_pin_model (
    // Clock
    input wire logic clk_in,
    // Requested level and pin drive
    input wire logic [7:0] level_in,
    output logic [7:0] pins_out
);
    // Pins move one edge after the request, as a board signal would lag the core
    always_ff @(posedge clk_in) begin
        pins_out <= level_in;
    end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the pin change interrupt block.
// Assumes the register map and reset values of the constants header.
`timescale 1ns/10ps
`include "pci_consts.svh"

module tb_top;
    import pci_pkg::*;
    // Clock, reset, bus and power signals
    logic clk, rstn, wr, rd, sleep, irq, wake;
    logic [`PCI_ADDR_W-1:0] addr;
    // Data, pin levels, enable copies
    logic [7:0] wdata, rdata, level, pins, r, f, nxt, old, e;
    logic [31:0] seed = 32'h00012697;
    // Reset value of every index, unmapped ones read zero
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    int bad_count = 0;
    int compares = 0;

    pci_pin_model pins_src (.clk_in(clk), .level_in(level), .pins_out(pins));
    pci_top uut (.CLK_IN(clk), .RSTN_IN(rstn), .WATCHED_PIN_IN(pins), .ADDR_IN(addr),
        .WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata),
        .SLEEP_IN(sleep), .IRQ_OUT(irq), .WAKE_OUT(wake));

    // Xorshift source, fixed seed keeps runs repeatable
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Flags expected from one level step and the two enable masks
    function automatic logic [7:0] exp_flags(input logic [7:0] was, now, re, fe);
        return (~was & now & re) | (was & ~now & fe);
    endfunction

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Free-running clock at 8 ns
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #(8 * 4000);
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        sleep = 1'b0;
        addr = '0;
        wdata = '0;
        level = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, unmapped indexes included
        for (int i = 0; i < 8; i++) begin
            rd_chk(i[2:0], rst_tab[i]);
        end
        @(posedge clk);
        #1 chk(rdata, 8'h00);
        // Writes to an unmapped index go nowhere
        wr_reg(3'h6, 8'hFF);
        rd_chk(3'h6, 8'h00);
        // Random enables and pin steps, first pass with both polarities armed
        for (int n = 0; n < 10; n++) begin
            r = (n == 0) ? 8'hFF : rnd();
            f = (n == 0) ? 8'hFF : rnd();
            nxt = rnd();
            wr_reg(`PCI_OFS_RISE, r);
            wr_reg(`PCI_OFS_FALL, f);
            wr_reg(`PCI_OFS_FLAGS, 8'h00);
            rd_chk(`PCI_OFS_RISE, r);
            rd_chk(`PCI_OFS_FALL, f);
            old = level;
            e = exp_flags(old, nxt, r, f);
            @(posedge clk);
            level <= nxt;
            repeat (6) @(posedge clk);
            rd_chk(`PCI_OFS_FLAGS, e);
            rd_chk(`PCI_OFS_CTRL, {7'h00, |e});
            chk({7'h00, irq}, 8'h00);
        end
        // Every pin steps with both polarities armed, master still off
        wr_reg(`PCI_OFS_RISE, 8'hFF);
        wr_reg(`PCI_OFS_FALL, 8'hFF);
        wr_reg(`PCI_OFS_STATUS, 8'hFF);
        @(posedge clk);
        level <= ~level;
        repeat (6) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        rd_chk(`PCI_OFS_STATUS, 8'hFF);
        // Master on raises the request; mask and one-to-clear take it away
        wr_reg(`PCI_OFS_CTRL, 8'h10);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h01);
        rd_chk(`PCI_OFS_CTRL, 8'h11);
        wr_reg(`PCI_OFS_MASK, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
        wr_reg(`PCI_OFS_MASK, 8'hFF);
        wr_reg(`PCI_OFS_STATUS, 8'hFF);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, irq}, 8'h00);
        // Edge during sleep wakes the core with the flags already latched
        wr_reg(`PCI_OFS_FLAGS, 8'h00);
        sleep <= 1'b1;
        @(posedge clk);
        level <= ~level;
        for (int i = 0; i < 10 && wake !== 1'b1; i++) begin
            @(posedge clk);
        end
        #1 chk({7'h00, wake}, 8'h01);
        rd_chk(`PCI_OFS_FLAGS, 8'hFF);
        wr_reg(`PCI_OFS_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk({7'h00, wake}, 8'h00);
        sleep <= 1'b0;
        // Clearing write slid across the edge: set wins up to the coinciding cycle
        wr_reg(`PCI_OFS_RISE, 8'h01);
        wr_reg(`PCI_OFS_FALL, 8'h01);
        for (int k = 0; k < 6; k++) begin
            wr_reg(`PCI_OFS_FLAGS, 8'h00);
            repeat (6) @(posedge clk);
            level <= level ^ 8'h01;
            repeat (k) @(posedge clk);
            wr_reg(`PCI_OFS_FLAGS, 8'h00);
            repeat (3) @(posedge clk);
            rd_chk(`PCI_OFS_FLAGS, (k <= 2) ? 8'h01 : 8'h00);
        end
        // Reset in mid-run clears enables and flags again
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(`PCI_OFS_RISE, 8'h00);
        rd_chk(`PCI_OFS_FLAGS, 8'h00);
        complete_run();
    end
endmodule
